// File: rsmc_pkg.sv
// Purpose: shared constants for the reset and stop-mode controller and its core-side partner
// Assumes: one clock, aclk at 125 MHz; aresetn stands for the power-on reset
// Notes: byte-wide special-function register port between the two ends
// Notes on behaviour
// - stop bit write enters stop after instruction
// - stop halts oscillator, cpu, digital peripherals
// - only a reset ends stop; restart 0x0000
// - enabled clock-loss detector ends stop by reset
// - regulator off in stop: pin/power only
// - stop and idle bits read zero
// - bits 7:2 general flags, reset zero
// - reset halts, reloads registers, disables interrupts
// - port latches 0xff open-drain, pull-ups kept
// - power-on/supply reset drives reset pin low
// - exit: clear pc, internal osc, watchdog /12
// - power-on flag set by power/supply reset
// - only power-on disables the supply monitor
// - writing power-on flag enables supply monitor
// - low supply holds reset, no extra delay
// - external pin reset sets pin flag
// - clock-loss enable bit, flag after its reset
// - comparator reset enable, flag after its reset
// - watchdog overflow resets, sets watchdog flag
// - code access above limit resets, memory flag
// - software reset bit forces reset, reads one
// - internal causes leave the reset pin alone
// - idle stops cpu; interrupt or reset ends it
package rsmc_pkg;
    localparam logic [7:0] PMC_ADDR = 8'h87;
    localparam logic [7:0] RCR_ADDR = 8'hef;
    localparam logic [7:0] REGC_ADDR = 8'hc9;
    localparam logic [7:0] PMC_RESET = 8'h00;
    localparam int PMC_IDLE_BIT = 0;
    localparam int PMC_STOP_BIT = 1;
    localparam int PMC_GF_LSB = 2;
    localparam int REGC_STOPOFF_BIT = 7;
    localparam int C_PIN = 0;
    localparam int C_POR = 1;
    localparam int C_MCD = 2;
    localparam int C_WDT = 3;
    localparam int C_SW = 4;
    localparam int C_CMP = 5;
    localparam int C_MEM = 6;
    localparam int NCAUSE = 7;
    localparam logic [6:0] CAUSE_POR_ONLY = 7'h02;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [3:0] WDT_DIV = 4'hc;
    localparam logic [7:0] PORT_LATCH_RESET = 8'hff;
    localparam int RELEASE_STAGES = 2;
    localparam logic [31:0] HOST_SFR_OFS = 32'h0000_0000;
    localparam logic [31:0] HOST_EVT_OFS = 32'h0000_0004;
    localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0008;
    localparam int H_SFR_WR_BIT = 16;
    localparam int H_SFR_RD_BIT = 17;
    localparam int H_EV_SUPPLY = 0;
    localparam int H_EV_CLKMISS = 1;
    localparam int H_EV_CMP = 2;
    localparam int H_EV_PIN = 3;
    localparam int H_EV_IRQ = 4;
    localparam int H_EV_WDT = 8;
    localparam int H_EV_MEM = 9;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : rsmc_pkg

// File: rsmc_if.sv
// Purpose: joins the controller end and the core-side end
// Assumes: reset pin is open drain, pulled high when nobody drives it
// Notes: the pin level is resolved here from both enables
`timescale 1ns/10ps
interface rsmc_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic instr_done;
    logic irq_pending;
    logic supply_low;
    logic clock_missing;
    logic comparator_low;
    logic wdt_overflow;
    logic mem_error;
    logic host_pin_oe;
    logic dev_pin_oe;
    logic rst_pin_level;
    logic sys_rst;
    logic cpu_run;
    logic osc_run;
    logic periph_run;
    logic regulator_on;
    logic irq_timer_disable;
    logic ports_force;
    logic [7:0] port_latch;
    logic weak_pullup;
    logic defaults_load;
    logic [15:0] reset_vector;
    logic [3:0] wdt_div;

    assign rst_pin_level = !(host_pin_oe | dev_pin_oe);

    modport dev (
        input sfr_addr, sfr_wr, sfr_rd, sfr_wdata, instr_done, irq_pending,
        input supply_low, clock_missing, comparator_low, wdt_overflow, mem_error, rst_pin_level,
        output sfr_rdata, dev_pin_oe, sys_rst, cpu_run, osc_run, periph_run, regulator_on,
        output irq_timer_disable, ports_force, port_latch, weak_pullup, defaults_load, reset_vector, wdt_div
    );
    modport host (
        output sfr_addr, sfr_wr, sfr_rd, sfr_wdata, instr_done, irq_pending,
        output supply_low, clock_missing, comparator_low, wdt_overflow, mem_error, host_pin_oe,
        input sfr_rdata, rst_pin_level, sys_rst, cpu_run, osc_run, periph_run, regulator_on
    );
endinterface : rsmc_if

// File: rsmc_release.sv
// Purpose: stretches a merged reset request and releases it on the clock
// Assumes: cause_any may rise in any cycle
// Notes: hold follows cause_any at once; release lags by two edges
`timescale 1ns/10ps
module rsmc_release (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cause_any,
    output logic hold,
    output logic release_pulse
);
    logic [rsmc_pkg::RELEASE_STAGES-1:0] stage_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            stage_r <= '1;
        else
            stage_r <= {stage_r[rsmc_pkg::RELEASE_STAGES-2:0], cause_any};
    end

    // fast assert, clocked release
    assign hold = cause_any | (|stage_r);
    assign release_pulse = stage_r[rsmc_pkg::RELEASE_STAGES-1] & ~(|stage_r[rsmc_pkg::RELEASE_STAGES-2:0]) & ~cause_any;
endmodule : rsmc_release

// File: rsmc_device.sv
// Purpose: reset merging, cause flags, stop and idle control
// Assumes: core pulses instr_done when the writing instruction retires
// Notes: stopped clocks are modelled by run enables; aclk itself never stops
`timescale 1ns/10ps
module rsmc_device (
    input wire logic aclk,
    input wire logic aresetn,
    rsmc_if.dev bus,
    output logic in_stop,
    output logic in_idle
);
    logic [5:0] gflags_r;
    logic reg_off_r;
    logic mon_en_r;
    logic mcd_en_r;
    logic cmp_en_r;
    logic sw_req_r;
    logic stop_pend_r;
    logic idle_pend_r;
    logic stop_r;
    logic idle_r;
    logic pin_low_r;
    logic [rsmc_pkg::NCAUSE-1:0] seen_r;
    logic [rsmc_pkg::NCAUSE-1:0] flags_r;
    logic [7:0] rdata_r;
    logic [rsmc_pkg::NCAUSE-1:0] cause;
    logic lock;
    logic hold;
    logic release_pulse;
    logic wr_ok;

    // regulator off in stop leaves only the pin and power cycling
    assign lock = stop_r & reg_off_r;

    always_comb
    begin
        cause = '0;
        cause[rsmc_pkg::C_PIN] = pin_low_r;
        cause[rsmc_pkg::C_POR] = mon_en_r & bus.supply_low & ~lock;
        // a stopped oscillator looks like a lost clock to the detector
        cause[rsmc_pkg::C_MCD] = mcd_en_r & (bus.clock_missing | stop_r) & ~lock;
        cause[rsmc_pkg::C_WDT] = bus.wdt_overflow & ~stop_r;
        cause[rsmc_pkg::C_SW] = sw_req_r;
        cause[rsmc_pkg::C_CMP] = cmp_en_r & bus.comparator_low & ~lock;
        cause[rsmc_pkg::C_MEM] = bus.mem_error & ~stop_r;
    end

    rsmc_release u_release (
        .aclk(aclk),
        .aresetn(aresetn),
        .cause_any(|cause),
        .hold(hold),
        .release_pulse(release_pulse)
    );

    assign wr_ok = bus.sfr_wr & ~hold;

    // sampled so the pin we drive ourselves cannot feed back in one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_low_r <= 1'b0;
        else
            pin_low_r <= ~bus.rst_pin_level & ~bus.dev_pin_oe;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            seen_r <= rsmc_pkg::CAUSE_POR_ONLY;
        else if (release_pulse)
            seen_r <= '0;
        else if (hold)
            seen_r <= seen_r | cause;
    end

    // flags move only when reset is released
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flags_r <= rsmc_pkg::CAUSE_POR_ONLY;
        else if (release_pulse)
        begin
            if (seen_r[rsmc_pkg::C_POR])
                flags_r <= rsmc_pkg::CAUSE_POR_ONLY;
            else
                flags_r <= seen_r;
        end
    end

    // monitor enable survives every reset except power-on
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mon_en_r <= 1'b0;
        else if (wr_ok && bus.sfr_addr == rsmc_pkg::RCR_ADDR && bus.sfr_wdata[rsmc_pkg::C_POR])
            mon_en_r <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
        begin
            mcd_en_r <= 1'b0;
            cmp_en_r <= 1'b0;
            sw_req_r <= 1'b0;
        end
        else if (wr_ok && bus.sfr_addr == rsmc_pkg::RCR_ADDR)
        begin
            mcd_en_r <= bus.sfr_wdata[rsmc_pkg::C_MCD];
            cmp_en_r <= cmp_en_r | bus.sfr_wdata[rsmc_pkg::C_CMP];
            sw_req_r <= bus.sfr_wdata[rsmc_pkg::C_SW];
        end
        else
            sw_req_r <= 1'b0;
    end

    // general flags return to their reset value while reset holds
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
            gflags_r <= rsmc_pkg::PMC_RESET[7:2];
        else if (wr_ok && bus.sfr_addr == rsmc_pkg::PMC_ADDR)
            gflags_r <= bus.sfr_wdata[7:rsmc_pkg::PMC_GF_LSB];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
            reg_off_r <= 1'b0;
        else if (wr_ok && bus.sfr_addr == rsmc_pkg::REGC_ADDR)
            reg_off_r <= bus.sfr_wdata[rsmc_pkg::REGC_STOPOFF_BIT];
    end

    // mode bits act on write and are never stored as readable data
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
        begin
            stop_pend_r <= 1'b0;
            idle_pend_r <= 1'b0;
        end
        else if (bus.instr_done)
        begin
            stop_pend_r <= 1'b0;
            idle_pend_r <= 1'b0;
        end
        else if (wr_ok && bus.sfr_addr == rsmc_pkg::PMC_ADDR)
        begin
            stop_pend_r <= stop_pend_r | bus.sfr_wdata[rsmc_pkg::PMC_STOP_BIT];
            idle_pend_r <= idle_pend_r | bus.sfr_wdata[rsmc_pkg::PMC_IDLE_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
            stop_r <= 1'b0;
        else if (bus.instr_done && stop_pend_r)
            stop_r <= 1'b1;
    end

    // entry in the same cycle as an interrupt wins; the next one wakes it
    always_ff @(posedge aclk)
    begin
        if (!aresetn || hold)
            idle_r <= 1'b0;
        else if (bus.instr_done && idle_pend_r)
            idle_r <= 1'b1;
        else if (bus.irq_pending)
            idle_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            rdata_r <= 8'h00;
        else if (bus.sfr_rd)
        begin
            case (bus.sfr_addr)
                rsmc_pkg::PMC_ADDR: rdata_r <= {gflags_r, 2'b00};
                rsmc_pkg::RCR_ADDR: rdata_r <= {1'b0, flags_r};
                rsmc_pkg::REGC_ADDR: rdata_r <= {reg_off_r, 7'h00};
                default: rdata_r <= 8'h00;
            endcase
        end
    end

    assign bus.sfr_rdata = rdata_r;
    // only power and supply causes pull the pin
    assign bus.dev_pin_oe = hold & (seen_r[rsmc_pkg::C_POR] | cause[rsmc_pkg::C_POR]);
    assign bus.sys_rst = hold;
    assign bus.cpu_run = ~hold & ~stop_r & ~idle_r;
    assign bus.osc_run = ~stop_r;
    assign bus.periph_run = ~hold & ~stop_r;
    assign bus.regulator_on = ~lock;
    assign bus.irq_timer_disable = hold | stop_r;
    assign bus.ports_force = hold;
    assign bus.port_latch = rsmc_pkg::PORT_LATCH_RESET;
    assign bus.weak_pullup = 1'b1;
    // one pulse tells the core to clear pc, pick internal osc, restart watchdog
    assign bus.defaults_load = release_pulse;
    assign bus.reset_vector = rsmc_pkg::RESET_VECTOR;
    assign bus.wdt_div = rsmc_pkg::WDT_DIV;
    assign in_stop = stop_r;
    assign in_idle = idle_r;
endmodule : rsmc_device

// File: rsmc_host.sv
// Purpose: core-side partner; software drives it over AXI4-Lite
// Assumes: one write and one read under way at a time
// Notes: each sfr write is followed one cycle later by instr_done
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/10ps
module rsmc_host (
    input wire logic aclk,
    input wire logic aresetn,
    rsmc_if.host bus,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic aw_got_r;
    logic w_got_r;
    logic [31:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [1:0] bresp_r;
    logic bvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic rvalid_r;
    logic [7:0] sfr_addr_r;
    logic [7:0] sfr_wdata_r;
    logic sfr_wr_r;
    logic sfr_rd_r;
    logic done_r;
    logic rd_wait_r;
    logic [7:0] rd_cap_r;
    logic [4:0] levels_r;
    logic [1:0] pulses_r;
    logic do_write;

    assign do_write = aw_got_r & w_got_r & ~bvalid_r;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 32'h0000_0000;
            wdata_r <= 32'h0000_0000;
        end
        else
        begin
            if (s_axi_awvalid && !aw_got_r)
            begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_got_r <= 1'b0;
            if (s_axi_wvalid && !w_got_r)
            begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
            end
            else if (do_write)
                w_got_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= rsmc_pkg::AXI_OKAY;
        end
        else if (do_write)
        begin
            bvalid_r <= 1'b1;
            bresp_r <= (awaddr_r[7:0] == rsmc_pkg::HOST_SFR_OFS[7:0] || awaddr_r[7:0] == rsmc_pkg::HOST_EVT_OFS[7:0])
                ? rsmc_pkg::AXI_OKAY : rsmc_pkg::AXI_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_r <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sfr_addr_r <= 8'h00;
            sfr_wdata_r <= 8'h00;
            sfr_wr_r <= 1'b0;
            sfr_rd_r <= 1'b0;
            levels_r <= 5'h00;
            pulses_r <= 2'h0;
        end
        else
        begin
            sfr_wr_r <= 1'b0;
            sfr_rd_r <= 1'b0;
            pulses_r <= 2'h0;
            if (do_write && awaddr_r[7:0] == rsmc_pkg::HOST_SFR_OFS[7:0])
            begin
                if (s_axi_wstrb[0])
                    sfr_addr_r <= wdata_r[7:0];
                if (s_axi_wstrb[1])
                    sfr_wdata_r <= wdata_r[15:8];
                sfr_wr_r <= wdata_r[rsmc_pkg::H_SFR_WR_BIT];
                sfr_rd_r <= wdata_r[rsmc_pkg::H_SFR_RD_BIT];
            end
            if (do_write && awaddr_r[7:0] == rsmc_pkg::HOST_EVT_OFS[7:0])
            begin
                levels_r <= wdata_r[rsmc_pkg::H_EV_IRQ:rsmc_pkg::H_EV_SUPPLY];
                pulses_r <= wdata_r[rsmc_pkg::H_EV_MEM:rsmc_pkg::H_EV_WDT];
            end
        end
    end

    // the writing instruction retires one cycle after its write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_r <= 1'b0;
            rd_wait_r <= 1'b0;
            rd_cap_r <= 8'h00;
        end
        else
        begin
            done_r <= sfr_wr_r;
            rd_wait_r <= sfr_rd_r;
            if (rd_wait_r)
                rd_cap_r <= bus.sfr_rdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= rsmc_pkg::AXI_OKAY;
        end
        else if (s_axi_arvalid && !rvalid_r)
        begin
            rvalid_r <= 1'b1;
            rresp_r <= rsmc_pkg::AXI_OKAY;
            case (s_axi_araddr[7:0])
                rsmc_pkg::HOST_SFR_OFS[7:0]: rdata_r <= {16'h0000, sfr_wdata_r, sfr_addr_r};
                rsmc_pkg::HOST_EVT_OFS[7:0]: rdata_r <= {27'h0000000, levels_r};
                rsmc_pkg::HOST_STAT_OFS[7:0]: rdata_r <= {18'h00000, bus.osc_run, bus.regulator_on, bus.rst_pin_level,
                    bus.periph_run, bus.cpu_run, bus.sys_rst, rd_cap_r};
                default:
                begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= rsmc_pkg::AXI_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_r <= 1'b0;
    end

    assign s_axi_awready = ~aw_got_r;
    assign s_axi_wready = ~w_got_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign bus.sfr_addr = sfr_addr_r;
    assign bus.sfr_wdata = sfr_wdata_r;
    assign bus.sfr_wr = sfr_wr_r;
    assign bus.sfr_rd = sfr_rd_r;
    assign bus.instr_done = done_r;
    assign bus.supply_low = levels_r[rsmc_pkg::H_EV_SUPPLY];
    assign bus.clock_missing = levels_r[rsmc_pkg::H_EV_CLKMISS];
    assign bus.comparator_low = levels_r[rsmc_pkg::H_EV_CMP];
    assign bus.host_pin_oe = levels_r[rsmc_pkg::H_EV_PIN];
    assign bus.irq_pending = levels_r[rsmc_pkg::H_EV_IRQ];
    assign bus.wdt_overflow = pulses_r[0];
    assign bus.mem_error = pulses_r[1];
endmodule : rsmc_host

// File: rsmc_properties.sv
// Purpose: concurrent checks on the link between the controller and the core side
// Assumes: one clock domain; aresetn is the power-on reset
// Notes: sees interface signals only, so stop is judged by the run enables
`timescale 1ns/10ps
module rsmc_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic instr_done,
    input wire logic wdt_overflow,
    input wire logic mem_error,
    input wire logic dev_pin_oe,
    input wire logic rst_pin_level,
    input wire logic sys_rst,
    input wire logic cpu_run,
    input wire logic osc_run,
    input wire logic periph_run,
    input wire logic ports_force,
    input wire logic [7:0] port_latch,
    input wire logic weak_pullup,
    input wire logic defaults_load,
    input wire logic [15:0] reset_vector,
    input wire logic [3:0] wdt_div
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_pin_holds_core: assert property (dev_pin_oe |-> sys_rst)
        else $error("reset pin driven outside reset");
    a_pin_forces_rst: assert property (!rst_pin_level && !dev_pin_oe |=> sys_rst)
        else $error("low reset pin did not reset");
    a_int_pin_quiet: assert property ((wdt_overflow || mem_error) && !dev_pin_oe |=> !dev_pin_oe)
        else $error("internal cause drove the reset pin");
    a_int_cause_rst: assert property ((wdt_overflow || mem_error) && osc_run |-> ##[0:1] sys_rst)
        else $error("watchdog or memory error without reset");
    a_reset_halts: assert property (sys_rst |-> !cpu_run && ports_force)
        else $error("core runs during reset");
    a_ports_known: assert property (ports_force |-> port_latch == rsmc_pkg::PORT_LATCH_RESET && weak_pullup)
        else $error("port state wrong in reset");
    a_exit_defaults: assert property (defaults_load |->
        (sys_rst && reset_vector == 16'h0000 && wdt_div == 4'hc) ##1 !sys_rst)
        else $error("defaults not loaded at release");
    a_release_lag: assert property ($fell(sys_rst) |-> $past(defaults_load))
        else $error("release without defaults pulse");
    a_stop_halts: assert property (!osc_run |-> !cpu_run && !periph_run)
        else $error("cpu or peripherals run with oscillator stopped");
    a_stop_entry: assert property (sfr_wr && !sys_rst && sfr_addr == rsmc_pkg::PMC_ADDR && sfr_wdata[1]
        ##1 instr_done && !sys_rst |=> !osc_run)
        else $error("stop not entered after the instruction");
    a_mode_bits_zero: assert property (sfr_rd && sfr_addr == rsmc_pkg::PMC_ADDR |=> sfr_rdata[1:0] == 2'b00)
        else $error("mode select bits read nonzero");
    a_sw_reset_len: assert property (sfr_wr && !sys_rst && sfr_addr == rsmc_pkg::RCR_ADDR && sfr_wdata[4]
        |=> sys_rst [*3] ##1 !sys_rst)
        else $error("software reset length wrong");
endmodule : rsmc_properties

// File: reset_and_stop_mode_control_tb.sv
// Purpose: drives the core-side end over AXI4-Lite against the controller end
// Assumes: host map at 0x00, 0x04, 0x08 as the package gives
// Notes: every read result is queued before the read and compared when rvalid is taken
`timescale 1ns/10ps
module reset_and_stop_mode_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic in_stop, in_idle;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] exp_q[$];
    logic [1:0] resp_q[$];
    logic [7:0] seed = 8'h20;
    logic [7:0] gf;
    // cause table: enable write, event word, expected cause flags
    logic [7:0] en[7] = '{8'h04, 8'h00, 8'h20, 8'h00, 8'h02, 8'h10, 8'h00};
    logic [31:0] ev[7] = '{32'h002, 32'h100, 32'h004, 32'h200, 32'h001, 32'h000, 32'h001};
    logic [7:0] fl[7] = '{8'h04, 8'h08, 8'h20, 8'h40, 8'h02, 8'h10, 8'h02};

    rsmc_if i_rsmc_if (.aclk(aclk), .aresetn(aresetn));
    rsmc_device i_rsmc_device (.aclk(aclk), .aresetn(aresetn), .bus(i_rsmc_if), .in_stop(in_stop), .in_idle(in_idle));
    rsmc_host i_rsmc_host (.aclk, .aresetn, .bus(i_rsmc_if), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rsmc_properties i_rsmc_properties (.aclk(aclk), .aresetn(aresetn), .sfr_addr(i_rsmc_if.sfr_addr),
        .sfr_wr(i_rsmc_if.sfr_wr), .sfr_rd(i_rsmc_if.sfr_rd), .sfr_wdata(i_rsmc_if.sfr_wdata),
        .sfr_rdata(i_rsmc_if.sfr_rdata), .instr_done(i_rsmc_if.instr_done), .wdt_overflow(i_rsmc_if.wdt_overflow),
        .mem_error(i_rsmc_if.mem_error), .dev_pin_oe(i_rsmc_if.dev_pin_oe), .rst_pin_level(i_rsmc_if.rst_pin_level),
        .sys_rst(i_rsmc_if.sys_rst), .cpu_run(i_rsmc_if.cpu_run), .osc_run(i_rsmc_if.osc_run),
        .periph_run(i_rsmc_if.periph_run), .ports_force(i_rsmc_if.ports_force), .port_latch(i_rsmc_if.port_latch),
        .weak_pullup(i_rsmc_if.weak_pullup), .defaults_load(i_rsmc_if.defaults_load),
        .reset_vector(i_rsmc_if.reset_vector), .wdt_div(i_rsmc_if.wdt_div));

    always #4 aclk = ~aclk;

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_sim;
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        chk(s_axi_bresp, rsmc_pkg::AXI_OKAY);
        s_axi_bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [7:0] e, input logic [1:0] r);
        exp_q.push_back(e);
        resp_q.push_back(r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : axi_rd

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        axi_wr(rsmc_pkg::HOST_SFR_OFS, {14'h0, 2'b01, d, a});
    endtask : sfr_wr

    // the captured byte lands in status two edges after the read strobe
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
        axi_wr(rsmc_pkg::HOST_SFR_OFS, {14'h0, 2'b10, 8'h00, a});
        repeat (2) @(posedge aclk);
        axi_rd(rsmc_pkg::HOST_STAT_OFS, e, rsmc_pkg::AXI_OKAY);
    endtask : sfr_rd

    task automatic wait_run;
        repeat (4) @(posedge aclk);
        while (i_rsmc_if.sys_rst !== 1'b0)
            @(posedge aclk);
    endtask : wait_run

    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0)
        begin
            chk(s_axi_rdata[7:0], exp_q.pop_front());
            chk(s_axi_rresp, resp_q.pop_front());
        end
    end

    // far above the few hundred cycles the sequence needs
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        wait_run();
        sfr_rd(rsmc_pkg::RCR_ADDR, 8'h02);
        sfr_rd(rsmc_pkg::PMC_ADDR, rsmc_pkg::PMC_RESET);
        axi_rd(32'h0000_0040, 8'h00, rsmc_pkg::AXI_SLVERR);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            gf = seed & 8'hfc;
            sfr_wr(rsmc_pkg::PMC_ADDR, gf);
            sfr_rd(rsmc_pkg::PMC_ADDR, gf);
        end
        sfr_wr(rsmc_pkg::PMC_ADDR, gf | 8'h01);
        repeat (3) @(posedge aclk);
        chk(in_idle, 1'b1);
        chk(i_rsmc_if.periph_run, 1'b1);
        sfr_rd(rsmc_pkg::PMC_ADDR, gf);
        axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h10);
        repeat (3) @(posedge aclk);
        chk(in_idle, 1'b0);
        axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h00);
        for (int i = 0; i < 7; i++)
        begin
            if (en[i] != 8'h00)
                sfr_wr(rsmc_pkg::RCR_ADDR, en[i]);
            if (ev[i] != 32'h0)
            begin
                axi_wr(rsmc_pkg::HOST_EVT_OFS, ev[i]);
                axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h0);
            end
            wait_run();
            sfr_rd(rsmc_pkg::RCR_ADDR, fl[i]);
        end
        // enabled clock-loss detector fires as soon as stop halts the oscillator
        sfr_wr(rsmc_pkg::RCR_ADDR, 8'h04);
        sfr_wr(rsmc_pkg::PMC_ADDR, 8'h02);
        wait_run();
        chk(in_stop, 1'b0);
        sfr_rd(rsmc_pkg::RCR_ADDR, 8'h04);
        sfr_wr(rsmc_pkg::REGC_ADDR, 8'h80);
        sfr_wr(rsmc_pkg::PMC_ADDR, gf | 8'h02);
        repeat (3) @(posedge aclk);
        chk(in_stop, 1'b1);
        chk(i_rsmc_if.regulator_on, 1'b0);
        axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h11);
        repeat (4) @(posedge aclk);
        chk(in_stop, 1'b1);
        chk(i_rsmc_if.sys_rst, 1'b0);
        axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h08);
        axi_wr(rsmc_pkg::HOST_EVT_OFS, 32'h00);
        wait_run();
        chk(in_stop, 1'b0);
        sfr_rd(rsmc_pkg::RCR_ADDR, 8'h01);
        sfr_rd(rsmc_pkg::PMC_ADDR, 8'h00);
        end_sim();
    end
endmodule : reset_and_stop_mode_control_tb
